//--- core/gz_gauge_zero.sv
// Purpose: two-gauge zero-return control, fault flags, register bus
// Assumes: classic wishbone master, async pins pass gz_sync
// Notes:   status read at the ack edge clears latched faults except overtemperature
//
// Overview of operation
// - enable plus auto mode starts zero return
// - mode plus continue bit runs unconditional return
// - busy gauge ignores its commands except abort
// - status shows zero return in progress
// - end stop reports success, frees gauge
// - accumulator loaded with preload before integration
// - step rate from step field and extension
// - counterclockwise full steps when zloc clear, one coil driven
// - integrate open terminal, other end grounded
// - each step: blank, then integrate
// - result above threshold means still moving
// - no motion and continue clear stops, succeeds
// - continue set steps on until enable cleared
// - one gauge zeroing; other request ignored
// - zero position assigned at stall step
// - after reset outputs off, config zero
// - default state on internal or external reset
// - fault flags except overtemperature held until read out
// - overtemperature disables gauge, flag until reenabled
// - overvoltage reported whether gauges enabled or not
// - undervoltage suppressed when both gauges disabled
// - calibration divisor outside 4..15 flags fault
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module gz_gauge_zero
   import gz_pkg::*;
#(
   parameter int unsigned STEP_CYC = gz_pkg::STEP_UNIT_CYC
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rstn,
   input  wire logic                 ce,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [gz_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [31:0]          wb_dat_i,
   output logic      [31:0]          wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 por_rst,
   input  wire logic [1:0]           emf_hi,
   input  wire logic [1:0]           ot_pin,
   input  wire logic                 uv_pin,
   input  wire logic                 ov_pin,
   input  wire logic [4:0]           cal_div,
   output logic      [1:0]           gauge_en,
   output logic      [3:0]           gauge0_coil,
   output logic      [3:0]           gauge1_coil,
   output logic      [1:0]           sense_open,
   output logic      [1:0]           sense_gnd
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic             ack;
      logic [31:0]      rdat;
      logic [CFG_W-1:0] cfg;
      logic [1:0]       en;
      logic             zloc;
      logic [POS_W-1:0] pos0;
      logic [POS_W-1:0] pos1;
      logic [1:0]       ot;
      logic             uv;
      logic             ov;
      logic             cal;
      logic [1:0]       ok;
   } gz_top_s;

   gz_top_s          r_ff;
   gz_top_s          nxt_r;

   logic [6:0]       pins_s;
   logic [1:0]       emf_s;
   logic [1:0]       ot_s;
   logic             uv_s;
   logic             ov_s;
   logic             por_s;

   logic             req;
   logic             wr;
   logic             rd_done;
   logic [31:0]      wd;
   logic [31:0]      stat;
   logic [1:0]       busy;
   logic [1:0]       done;
   logic [1:0]       mov;
   logic [1:0]       integ;
   logic [1:0]       start;
   logic [1:0]       abort;
   logic [ACC_W-1:0] acc0;
   logic [ACC_W-1:0] acc1;
   logic             cmd_wr;
   logic             g;
   logic             cal_bad;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // byte-lane merge of a write into a register image
   function automatic logic [31:0] merge
   (
      input logic [31:0] old,
      input logic [31:0] nw,
      input logic [3:0]  sel
   );
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++)
      begin
         if (sel[i])
            m[8*i +: 8] = nw[8*i +: 8];
      end
      return m;
   endfunction

   // sticky flag: event wins over clear
   function automatic logic sticky
   (
      input logic q,
      input logic clr,
      input logic evt
   );
      return (q & ~clr) | evt;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   gz_sync #(.W(7)) u_sync
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .ce       (ce),
      .d        ({por_rst, ov_pin, uv_pin, ot_pin, emf_hi}),
      .q        (pins_s)
   );

   assign emf_s = pins_s[1:0];
   assign ot_s  = pins_s[3:2];
   assign uv_s  = pins_s[4];
   assign ov_s  = pins_s[5];
   assign por_s = pins_s[6];

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   assign req     = wb_cyc_i & wb_stb_i;
   // writes and read side effects land on the ack edge
   assign wr      = req & wb_we_i & r_ff.ack;
   assign rd_done = req & ~wb_we_i & r_ff.ack
                    & (wb_adr_i == OFS_STATUS);
   assign cmd_wr  = wr & (wb_adr_i == OFS_ZR_CMD);
   assign wd      = merge(32'h0000_0000, wb_dat_i, wb_sel_i);
   assign g       = wd[CMD_SEL];

   // ----------------------------------------------------------------
   // arbiter and command decode
   // ----------------------------------------------------------------
   always_comb
   begin
      start = 2'b00;
      abort = 2'b00;
      if (cmd_wr && wd[CMD_EN] && wd[CMD_MODE]
          && busy == 2'b00 && r_ff.en[g])
         start[g] = 1'b1;
      if (cmd_wr && !wd[CMD_EN])
         abort[g] = 1'b1;
      abort = abort | ~r_ff.en | ot_s;
   end

   assign cal_bad = (cal_div < CAL_MIN) || (cal_div > CAL_MAX);

   // ----------------------------------------------------------------
   // per-gauge engines
   // ----------------------------------------------------------------
   gz_zero_engine #(.STEP_CYC(STEP_CYC)) u_eng0
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .ce       (ce),
      .clr      (por_s),
      .start    (start[0]),
      .abort    (abort[0]),
      .cos_in   (wd[CMD_COS]),
      .cfg_in   (r_ff.cfg),
      .ccw      (~r_ff.zloc),
      .emf_hi   (emf_s[0]),
      .busy     (busy[0]),
      .done     (done[0]),
      .moving   (mov[0]),
      .integ    (integ[0]),
      .coil     (gauge0_coil),
      .acc      (acc0)
   );

   gz_zero_engine #(.STEP_CYC(STEP_CYC)) u_eng1
   (
      .core_clk (core_clk),
      .rstn     (rstn),
      .ce       (ce),
      .clr      (por_s),
      .start    (start[1]),
      .abort    (abort[1]),
      .cos_in   (wd[CMD_COS]),
      .cfg_in   (r_ff.cfg),
      .ccw      (~r_ff.zloc),
      .emf_hi   (emf_s[1]),
      .busy     (busy[1]),
      .done     (done[1]),
      .moving   (mov[1]),
      .integ    (integ[1]),
      .coil     (gauge1_coil),
      .acc      (acc1)
   );

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   always_comb
   begin
      stat                    = 32'h0000_0000;
      stat[ST_OT +: 2]        = r_ff.ot;
      stat[ST_UV]             = r_ff.uv;
      stat[ST_OV]             = r_ff.ov;
      stat[ST_CAL]            = r_ff.cal;
      stat[ST_BUSY +: 2]      = busy;
      stat[ST_OK +: 2]        = r_ff.ok;
      stat[ST_MOV +: 2]       = mov;
      stat[ST_ACC +: ACC_W]   = busy[1] ? acc1 : acc0;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      nxt_r      = r_ff;
      nxt_r.ack  = req & ~r_ff.ack;
      if (req && !r_ff.ack)
      begin
         unique case (wb_adr_i)
            OFS_ZR_CFG: nxt_r.rdat = 32'(r_ff.cfg);
            OFS_GCTL:   nxt_r.rdat = 32'({r_ff.zloc, 5'h00, r_ff.en});
            OFS_STATUS: nxt_r.rdat = stat;
            OFS_POS0:   nxt_r.rdat = 32'(r_ff.pos0);
            OFS_POS1:   nxt_r.rdat = 32'(r_ff.pos1);
            default:    nxt_r.rdat = 32'h0000_0000;
         endcase
      end

      if (wr)
      begin
         unique case (wb_adr_i)
            OFS_ZR_CFG:
               nxt_r.cfg = CFG_W'(merge(32'(r_ff.cfg), wb_dat_i,
                                        wb_sel_i));
            OFS_GCTL:
            begin
               for (int i = 0; i < 2; i++)
               begin
                  if (!busy[i] && wb_sel_i[0])
                  begin
                     nxt_r.en[i] = wb_dat_i[i];
                     if (wb_dat_i[i] && !ot_s[i])
                        nxt_r.ot[i] = 1'b0;
                  end
               end
               if (busy == 2'b00 && wb_sel_i[0])
                  nxt_r.zloc = wb_dat_i[CTL_ZLOC];
            end
            OFS_POS0:
               if (!busy[0])
                  nxt_r.pos0 = POS_W'(merge(32'(r_ff.pos0),
                                            wb_dat_i, wb_sel_i));
            OFS_POS1:
               if (!busy[1])
                  nxt_r.pos1 = POS_W'(merge(32'(r_ff.pos1),
                                            wb_dat_i, wb_sel_i));
            default:
               nxt_r.cfg = r_ff.cfg;
         endcase
      end

      // zero position taken at the stall step
      if (done[0])
         nxt_r.pos0 = '0;
      if (done[1])
         nxt_r.pos1 = '0;

      // overtemperature shuts the gauge and holds its flag
      for (int i = 0; i < 2; i++)
      begin
         if (ot_s[i])
         begin
            nxt_r.en[i] = 1'b0;
            nxt_r.ot[i] = 1'b1;
         end
      end

      nxt_r.uv  = sticky(r_ff.uv, rd_done,
                         uv_s & (r_ff.en != 2'b00));
      nxt_r.ov  = sticky(r_ff.ov, rd_done, ov_s);
      nxt_r.cal = sticky(r_ff.cal, rd_done, cal_bad);
      nxt_r.ok  = {sticky(r_ff.ok[1], rd_done, done[1]),
                   sticky(r_ff.ok[0], rd_done, done[0])};

      if (por_s)
         nxt_r = '0;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         r_ff <= '0;
      else if (ce)
         r_ff <= nxt_r;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign wb_ack_o   = r_ff.ack;
   assign wb_dat_o   = r_ff.rdat;
   assign gauge_en   = r_ff.en;
   // open terminal sensed while integrating, far end grounded
   assign sense_open = integ;
   assign sense_gnd  = busy;
endmodule

//--- pkg/gz_pkg.sv
// Purpose: shared constants and types of the gauge zero-return block
// Assumes: 10 MHz core clock, 32-bit classic wishbone register bus
// Notes:   offsets are byte addresses of aligned words
package gz_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int          ADR_W        = 8;
   localparam logic [7:0]  OFS_ZR_CMD   = 8'h00;
   localparam logic [7:0]  OFS_ZR_CFG   = 8'h04;
   localparam logic [7:0]  OFS_GCTL     = 8'h08;
   localparam logic [7:0]  OFS_STATUS   = 8'h0C;
   localparam logic [7:0]  OFS_POS0     = 8'h10;
   localparam logic [7:0]  OFS_POS1     = 8'h14;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CMD_SEL   = 0;
   localparam int CMD_EN    = 1;
   localparam int CMD_MODE  = 2;
   localparam int CMD_COS   = 4;
   localparam int CFG_W     = 13;
   localparam int CFG_BLANK = 4;
   localparam int CFG_PRE   = 5;
   localparam int CFG_EXT   = 11;
   localparam int CTL_ZLOC  = 7;
   localparam int ST_OT     = 0;
   localparam int ST_UV     = 2;
   localparam int ST_OV     = 3;
   localparam int ST_CAL    = 4;
   localparam int ST_BUSY   = 5;
   localparam int ST_OK     = 7;
   localparam int ST_MOV    = 9;
   localparam int ST_ACC    = 16;
   localparam int POS_W     = 12;
   localparam int ACC_W     = 8;

   // ----------------------------------------------------------------
   // reset values and limits
   // ----------------------------------------------------------------
   localparam logic [12:0] CFG_RST    = 13'h0000;
   localparam logic [7:0]  ACC_THRESH = 8'h20;
   localparam logic [4:0]  CAL_MIN    = 5'h04;
   localparam logic [4:0]  CAL_MAX    = 5'h0F;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ        = 10;
   localparam int STEP_UNIT_US   = 800;
   localparam int STEP_UNIT_CYC  = STEP_UNIT_US * CLK_MHZ;
   localparam int BLANK_UNIT_US  = 200;
   localparam int BLANK_UNIT_CYC = BLANK_UNIT_US * CLK_MHZ;
   localparam int TMR_W          = 21;

   typedef enum logic [1:0]
   {
      GZ_IDLE  = 2'b00,
      GZ_BLANK = 2'b01,
      GZ_INTEG = 2'b11
   } gz_eng_e;

endpackage

//--- core/gz_sync.sv
// Purpose: two-flop synchroniser for asynchronous pins
// Assumes: inputs may change at any time
// Notes:   first stage is read only by the second
`timescale 1ns/1ps
module gz_sync
#(
   parameter int W = 1
)
(
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } gz_sync_s;

   gz_sync_s st_ff;
   gz_sync_s nxt_st;

   always_comb
   begin
      nxt_st = st_ff;
      if (ce)
      begin
         nxt_st.s1 = d;
         nxt_st.s2 = st_ff.s1;
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   assign q = st_ff.s2;
endmodule

//--- core/gz_zero_engine.sv
// Purpose: one gauge zero-return stepper with emf integration
// Assumes: emf_hi already synchronised
// Notes:   config is latched at start so each gauge keeps its own
`timescale 1ns/1ps
module gz_zero_engine
   import gz_pkg::*;
#(
   parameter int unsigned STEP_CYC = gz_pkg::STEP_UNIT_CYC
)
(
   input  wire logic                core_clk,
   input  wire logic                rstn,
   input  wire logic                ce,
   input  wire logic                clr,
   input  wire logic                start,
   input  wire logic                abort,
   input  wire logic                cos_in,
   input  wire logic [CFG_W-1:0]    cfg_in,
   input  wire logic                ccw,
   input  wire logic                emf_hi,
   output logic                     busy,
   output logic                     done,
   output logic                     moving,
   output logic                     integ,
   output logic [3:0]               coil,
   output logic [ACC_W-1:0]         acc
);
   typedef struct packed
   {
      gz_eng_e          st;
      logic             cos;
      logic [CFG_W-1:0] cfg;
      logic             ccw;
      logic [1:0]       ph;
      logic [TMR_W-1:0] tmr;
      logic [ACC_W-1:0] acc;
      logic             mov;
      logic             done;
   } gz_eng_s;

   gz_eng_s          s_ff;
   gz_eng_s          nxt_s;
   logic [TMR_W-1:0] step_len;
   logic [TMR_W-1:0] blank_len;
   logic [ACC_W-1:0] pre;

   always_comb
   begin
      step_len  = (TMR_W'(STEP_CYC) * (TMR_W'(16) - TMR_W'(s_ff.cfg[3:0])))
                  << s_ff.cfg[CFG_EXT +: 2];
      blank_len = TMR_W'(BLANK_UNIT_CYC) << s_ff.cfg[CFG_BLANK];
      pre       = ACC_W'(s_ff.cfg[CFG_PRE +: 6]);
      nxt_s      = s_ff;
      nxt_s.done = 1'b0;
      unique case (s_ff.st)
         GZ_IDLE:
            if (start)
            begin
               nxt_s.st  = GZ_BLANK;
               nxt_s.cos = cos_in;
               nxt_s.cfg = cfg_in;
               nxt_s.ccw = ccw;
               nxt_s.tmr = '0;
               nxt_s.mov = 1'b1;
            end
         GZ_BLANK:
         begin
            nxt_s.tmr = s_ff.tmr + 1'b1;
            if (s_ff.tmr >= blank_len - 1'b1)
            begin
               nxt_s.st  = GZ_INTEG;
               nxt_s.acc = pre;
            end
         end
         GZ_INTEG:
         begin
            nxt_s.tmr = s_ff.tmr + 1'b1;
            if (emf_hi && s_ff.acc != '1)
               nxt_s.acc = s_ff.acc + 1'b1;
            if (s_ff.tmr >= step_len - 1'b1)
            begin
               nxt_s.mov = s_ff.acc > ACC_THRESH;
               nxt_s.tmr = '0;
               if (s_ff.acc > ACC_THRESH || s_ff.cos)
               begin
                  nxt_s.st = GZ_BLANK;
                  nxt_s.ph = s_ff.ccw ? s_ff.ph - 1'b1
                                      : s_ff.ph + 1'b1;
               end
               else
               begin
                  nxt_s.st   = GZ_IDLE;
                  nxt_s.done = 1'b1;
                  nxt_s.mov  = 1'b0;
               end
            end
         end
         default:
            nxt_s.st = GZ_IDLE;
      endcase
      if (abort && s_ff.st != GZ_IDLE)
      begin
         nxt_s.st  = GZ_IDLE;
         nxt_s.mov = 1'b0;
      end
      if (clr)
         nxt_s = '0;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         s_ff <= '0;
      else if (ce)
         s_ff <= nxt_s;
   end

   assign busy   = s_ff.st != GZ_IDLE;
   assign done   = s_ff.done;
   assign moving = s_ff.mov;
   assign integ  = s_ff.st == GZ_INTEG;
   // one coil at a time: {b-, a-, b+, a+}
   assign coil   = busy ? 4'h1 << s_ff.ph : 4'h0;
   assign acc    = s_ff.acc;
endmodule

//--- testbench/gz_checker.sv
// Purpose: concurrent checks on the gauge zero-return top ports
// Assumes: ce high, zero location left at counterclockwise
// Notes:   bound to the top from the bench file
`timescale 1ns/1ps
module gz_checker
   import gz_pkg::*;
#(
   parameter int unsigned STEP_CYC = 8000
)
(
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        por_rst,
   input wire logic [1:0]  emf_hi,
   input wire logic [1:0]  ot_pin,
   input wire logic        uv_pin,
   input wire logic        ov_pin,
   input wire logic [4:0]  cal_div,
   input wire logic [1:0]  gauge_en,
   input wire logic [3:0]  gauge0_coil,
   input wire logic [3:0]  gauge1_coil,
   input wire logic [1:0]  sense_open,
   input wire logic [1:0]  sense_gnd
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce
      |=> wb_ack_o) else $error("bus ack late");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held");
   chk_one_coil: assert property ($onehot0(gauge0_coil)
      && $onehot0(gauge1_coil)) else $error("two coils driven");
   chk_ccw_g0: assert property (gauge0_coil != 4'h0
      && $past(gauge0_coil) != 4'h0 && $changed(gauge0_coil)
      |-> gauge0_coil == {$past(gauge0_coil[0]), $past(gauge0_coil[3:1])})
      else $error("gauge0 step not ccw");
   chk_ccw_g1: assert property (gauge1_coil != 4'h0
      && $past(gauge1_coil) != 4'h0 && $changed(gauge1_coil)
      |-> gauge1_coil == {$past(gauge1_coil[0]), $past(gauge1_coil[3:1])})
      else $error("gauge1 step not ccw");
   chk_open_gnd: assert property ((sense_open & ~sense_gnd) == 2'b00)
      else $error("open without ground");
   chk_single_zero: assert property (sense_gnd != 2'b11)
      else $error("both gauges zeroing");
   chk_blank_first: assert property ($rose(sense_gnd[0])
      |-> !sense_open[0] [*8]) else $error("no blanking");
   chk_ot_off: assert property (ot_pin[0] [*5] |-> !gauge_en[0])
      else $error("hot gauge enabled");
   chk_off_idle: assert property (!gauge_en[0] [*3]
      |-> gauge0_coil == 4'h0 && !sense_gnd[0])
      else $error("off gauge driven");
   chk_por_off: assert property (por_rst [*4]
      |-> gauge_en == 2'b00 && gauge1_coil == 4'h0)
      else $error("por kept state");

   cover property (sense_open[0]);
   cover property ($fell(sense_gnd[0]));
   cover property ($rose(sense_gnd[1]));
   cover property (ot_pin[0] && !gauge_en[0]);
endmodule

//--- testbench/gz_motor_model.sv
// Purpose: pointer model answering the emf comparator pins
// Assumes: each coil change is one full step toward the stop
// Notes:   moves steps with motion, then the pointer sits stalled
`timescale 1ns/1ps
module gz_motor_model
(
   input  wire logic       core_clk,
   input  wire logic [3:0] gauge0_coil,
   input  wire logic [3:0] gauge1_coil,
   input  wire logic [1:0] sense_open,
   input  wire logic [7:0] moves,
   output logic      [1:0] emf_hi
);
   int         steps [2] = '{0, 0};
   logic [3:0] last  [2] = '{4'h0, 4'h0};
   logic [3:0] coil  [2];

   assign coil[0] = gauge0_coil;
   assign coil[1] = gauge1_coil;

   always @(posedge core_clk)
   begin
      for (int g = 0; g < 2; g++)
      begin
         // idle pointer is parked on a full step
         if (coil[g] == 4'h0)
            steps[g] <= 0;
         else if (coil[g] != last[g])
            steps[g] <= steps[g] + 1;
         last[g] <= coil[g];
      end
   end

   always_comb
   begin
      for (int g = 0; g < 2; g++)
         emf_hi[g] = sense_open[g] && steps[g] <= int'(moves);
   end
endmodule

//--- testbench/tb.sv
// Purpose: self-checking bench for the gauge zero-return top
// Assumes: short step parameter, motor model on the emf pins
// Notes:   status expectations come from the integer model
`timescale 1ns/1ps
module tb;
   import gz_pkg::*;
   localparam int SC   = 300;
   localparam int STEP = SC * 16;
   localparam logic [31:0] MK = 32'hFFFFF9FF;
   logic        core_clk = 1'b0;
   logic        rstn     = 1'b0;
   logic        ce       = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   logic        por_rst  = 1'b0;
   logic [1:0]  ot_pin   = 2'b00;
   logic        uv_pin   = 1'b0;
   logic        ov_pin   = 1'b0;
   logic [4:0]  cal_div  = 5'h08;
   logic [7:0]  moves    = 8'h02;
   logic [31:0] lfsr     = 32'h5EE3;
   logic [31:0] wb_dat_o, q;
   logic        wb_ack_o;
   logic [1:0]  emf_hi, gauge_en, sense_open, sense_gnd;
   logic [3:0]  gauge0_coil, gauge1_coil;
   int miscompares = 0;
   int total_checks = 0;
   int ticks = 0;
   int n, t0, m_ot, m_uv, m_ov, m_cal, m_ok, m_busy, m_acc;

   always #50 core_clk = ~core_clk;
   always @(posedge core_clk) ticks <= ticks + 1;

   gz_gauge_zero #(.STEP_CYC(SC)) dut (.*);
   gz_motor_model mot (.core_clk, .gauge0_coil, .gauge1_coil,
                       .sense_open, .moves, .emf_hi);

   function automatic logic [31:0] mstat();
      return (32'(m_acc) << ST_ACC) | (32'(m_ok) << ST_OK)
           | (32'(m_busy) << ST_BUSY) | (32'(m_cal) << ST_CAL)
           | (32'(m_ov) << ST_OV) | (32'(m_uv) << ST_UV) | 32'(m_ot);
   endfunction

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do
      begin
         @(posedge core_clk);
         k++;
      end
      while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (k >= 20)
      begin
         miscompares++;
         results();
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      cmp(q, exp);
   endtask

   // status read clears the sticky model flags except thermal
   task automatic rs(input logic [31:0] m);
      wb(1'b0, OFS_STATUS, 32'h0);
      cmp(q & m, mstat() & m);
      m_uv = 0;
      m_ov = 0;
      m_cal = 0;
      m_ok = 0;
   endtask

   task automatic pins(input logic v);
      @(posedge core_clk);
      ov_pin <= v;
      uv_pin <= v;
      repeat (6) @(posedge core_clk);
   endtask

   initial
   begin
      {m_ot, m_uv, m_ov, m_cal, m_ok, m_busy, m_acc} = '0;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      rs(MK);
      rd(OFS_ZR_CFG, 32'h0);
      rd(8'h40, 32'h0);
      cal_div <= 5'h03;
      pins(1'b1);
      cal_div <= 5'h0F;
      pins(1'b0);
      m_ov = 1;
      m_cal = 1;
      rs(MK);
      rs(MK);
      for (int i = 0; i < 4; i++)
      begin
         lfsr = lfsr_next(lfsr);
         cal_div <= (i == 0) ? 5'h04 : 5'(4 + lfsr[7:0] % 12);
         wb(1'b1, OFS_ZR_CFG, lfsr);
         rd(OFS_ZR_CFG, {19'h0, lfsr[12:0]});
         rs(MK);
      end
      wb(1'b1, OFS_GCTL, 32'h3);
      pins(1'b1);
      pins(1'b0);
      m_uv = 1;
      m_ov = 1;
      rs(MK);
      ot_pin <= 2'b01;
      repeat (8) @(posedge core_clk);
      cmp(32'(gauge_en), 32'h2);
      ot_pin <= 2'b00;
      m_ot = 1;
      rs(MK);
      rs(MK);
      wb(1'b1, OFS_GCTL, 32'h3);
      m_ot = 0;
      rs(MK);
      wb(1'b1, OFS_POS0, 32'hC);
      wb(1'b1, OFS_ZR_CFG, 32'h10 << CFG_PRE);
      wb(1'b1, OFS_ZR_CMD, 32'h6);
      t0 = ticks;
      m_busy = 1;
      rs(32'hF9FF);
      wb(1'b1, OFS_ZR_CMD, 32'h7);
      wb(1'b1, OFS_GCTL, 32'h2);
      wb(1'b1, OFS_POS0, 32'h55);
      cmp(32'(sense_gnd), 32'h1);
      cmp(32'(gauge_en), 32'h3);
      wb(1'b1, OFS_GCTL, 32'h1);
      @(posedge core_clk);
      cmp(32'(gauge_en), 32'h1);
      wb(1'b1, OFS_GCTL, 32'h3);
      n = 0;
      while (sense_gnd[0] === 1'b1 && n < 6 * STEP)
      begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 6 * STEP)
      begin
         miscompares++;
         results();
      end
      cmp(32'((ticks - t0) / STEP), 32'h3);
      m_busy = 0;
      m_ok = 1;
      m_acc = 16;
      rs(MK);
      rd(OFS_POS0, 32'h0);
      wb(1'b1, OFS_POS0, 32'h18);
      rd(OFS_POS0, 32'h18);
      wb(1'b1, OFS_ZR_CMD, 32'h17);
      repeat (4 * STEP) @(posedge core_clk);
      m_busy = 2;
      rs(32'hF9FF);
      wb(1'b1, OFS_ZR_CMD, 32'h1);
      repeat (4) @(posedge core_clk);
      m_busy = 0;
      rs(32'hF9FF);
      por_rst <= 1'b1;
      repeat (6) @(posedge core_clk);
      por_rst <= 1'b0;
      repeat (4) @(posedge core_clk);
      cmp(32'(gauge_en), 32'h0);
      rd(OFS_ZR_CFG, 32'h0);
      m_acc = 0;
      rs(MK);
      results();
   end
endmodule

bind gz_gauge_zero gz_checker #(.STEP_CYC(STEP_CYC)) chk (.*);
